// ### common/lcd_decoder_pkg.sv
// Constants shared by the instruction decoder: opcodes, select codes, memory layout and timing.
package lcd_decoder_pkg;

    // ==========================================
    // Clock and oscillator
    // ==========================================
    localparam longint CLK_HZ   = 40_000_000;
    localparam longint OSC_HZ   = 145_000;
    localparam longint NS_PER_S = 1_000_000_000;
    localparam int     OSC_DIV_DEFAULT = int'((CLK_HZ + OSC_HZ / 2) / OSC_HZ);

    // ==========================================
    // Times in nanoseconds and oscillator ticks (rounded up)
    // ==========================================
    localparam longint INIT_BUSY_NS = 1_500_000;
    localparam longint RST_LOW_NS   = 1_200_000;
    localparam longint RST_BUSY_NS  = 250_000;
    localparam longint WRITE_NS     = 41_380;
    localparam longint CLEAR_NS     = 234_480;
    localparam logic [7:0] INIT_TICKS  = 8'((INIT_BUSY_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [7:0] RST_LOW_TICKS = 8'((RST_LOW_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [7:0] RST_BUSY_TICKS = 8'((RST_BUSY_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [7:0] WRITE_TICKS = 8'((WRITE_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam logic [7:0] CLEAR_TICKS = 8'((CLEAR_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);

    // ==========================================
    // Instruction word layout
    // ==========================================
    localparam int SEL_HI = 15;
    localparam int SEL_LO = 14;
    localparam int OP_HI  = 13;
    localparam int OP_LO  = 8;
    localparam logic [1:0] SEL_MASTER = 2'h2;
    localparam logic [1:0] SEL_SLAVE  = 2'h1;

    localparam logic [5:0] OP_TEST      = 6'h1F;
    localparam logic [5:0] OP_CLEAR     = 6'h19;
    localparam logic [5:0] OP_HOME      = 6'h11;
    localparam logic [5:0] OP_ENTRY     = 6'h08;
    localparam logic [5:0] OP_DISP_CTL  = 6'h09;
    localparam logic [5:0] OP_ADDR_SHIFT = 6'h12;
    localparam logic [5:0] OP_DISP_SHIFT = 6'h0A;
    localparam logic [5:0] OP_PORT      = 6'h0B;
    localparam logic [5:0] OP_CONTRAST  = 6'h0C;
    localparam logic [5:0] OP_DOT_SHIFT = 6'h0D;
    localparam logic [5:0] OP_DISP_MODE = 6'h0E;
    localparam logic [5:0] OP_SET_DDMK  = 6'h13;
    localparam logic [5:0] OP_SET_CG    = 6'h10;
    localparam logic [5:0] OP_WRITE     = 6'h18;
    localparam logic [5:0] OP_KEY_READ  = 6'h27;

    // ==========================================
    // Memory layout
    // ==========================================
    localparam int         DD_DEPTH   = 14;
    localparam int         MK_DEPTH   = 12;
    localparam int         CG_DEPTH   = 256;
    localparam int         FONT_W     = 5;
    localparam logic [7:0] DD_LAST    = 8'h0D;
    localparam logic [7:0] MK_BASE    = 8'h10;
    localparam logic [7:0] MK_LAST    = 8'h1B;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [7:0] HOME_ADDR  = 8'h00;
    localparam logic [7:0] KEY_NONE   = 8'h00;

    typedef enum logic [1:0] {
        TGT_DD = 2'h0,
        TGT_MK = 2'h1,
        TGT_CG = 2'h2
    } ram_target_t;

endpackage : lcd_decoder_pkg

// ### rtl/lcd_instruction_decoder.sv
// Instruction decoder and system control of the character LCD controller.
//
// Overview of operation
// - Single key sets its return and scan bits.
// - Vertical-line multi-press reported; horizontal not resolved.
// - Power-up init keeps busy 1.5ms.
// - Reset pin low over 1.2ms resets all.
// - Busy 250us after reset pin released.
// - Top two bits select master or slave.
// - Master and slave share the same lines.
// - Instruction and data held in holding registers.
// - Bits 13..8 opcode, bits 7..0 operand.
// - Busy times scale with oscillator period.
// - RAM write busy 41.38us; setup instructions none.
// - Clear fills spaces, homes, forces increment.
// - Return home resets address and shift.
// - Chips keep independent frame and blink timing (no frame or blink timing here; blink_on is only a register bit).
// - Scroll spacing inserted except after 12th (no scroll spacing logic in this decoder).
// - Key result read as 8-bit value.
// - Key result zero idle, frozen during read.
`timescale 1ns/1ps
`default_nettype none

module lcd_instruction_decoder
    import lcd_decoder_pkg::*;
#(
    parameter logic [1:0] OWN_SELECT = SEL_MASTER,
    parameter int         OSC_DIV    = OSC_DIV_DEFAULT,
    parameter int         DIV_W      = 9
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        reset_pin_n,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        key_sample_valid,
    input  wire logic [3:0]  key_return_lines,
    input  wire logic [7:0]  key_scan_lines,
    output var  logic        init_busy_flag,
    output var  logic [7:0]  address_counter,
    output var  logic        entry_increment,
    output var  logic        entry_shift,
    output var  logic [4:0]  display_offset,
    output var  logic        display_on,
    output var  logic        icon_on,
    output var  logic        blink_on,
    output var  logic [3:0]  static_port,
    output var  logic [3:0]  contrast,
    output var  logic [2:0]  dot_shift,
    output var  logic        keyscan_on,
    output var  logic        power_down,
    output var  logic [7:0]  key_read_data,
    output var  logic        key_read_valid,
    output var  logic        test_mode
);

    // ==========================================
    // State
    // ==========================================
    typedef enum logic [3:0] {
        ST_INIT = 4'h1,
        ST_IDLE = 4'h2,
        ST_BUSY = 4'h4,
        ST_HOLD = 4'h8
    } phase_t;

    typedef struct packed {
        phase_t                               st;
        logic [DIV_W-1:0]                     div;
        logic                                 tick;
        logic [7:0]                           busy_cnt;
        logic [7:0]                           low_cnt;
        logic                                 busy;
        logic                                 pend;
        logic [15:0]                          instruction_holding_reg;
        logic [7:0]                           data_holding_reg;
        logic [7:0]                           ac;
        ram_target_t                          tgt;
        logic                                 inc;
        logic                                 shf;
        logic [4:0]                           ofs;
        logic                                 disp;
        logic                                 icon;
        logic                                 blink;
        logic [3:0]                           port;
        logic [3:0]                           evr;
        logic [2:0]                           dots;
        logic                                 kscan;
        logic                                 pd;
        logic [DD_DEPTH-1:0][7:0]             display_text_ram;
        logic [MK_DEPTH-1:0][FONT_W-1:0]      icon_ram;
        logic [CG_DEPTH-1:0][FONT_W-1:0]      glyph_ram;
        logic [7:0]                           key_reg;
        logic [7:0]                           key_out;
        logic                                 key_vld;
        logic                                 test;
    } state_t;

    localparam state_t RESET_STATE = '{
        st: ST_INIT, busy_cnt: INIT_TICKS, busy: 1'b1, ac: HOME_ADDR, tgt: TGT_DD, inc: 1'b1, kscan: 1'b1,
        display_text_ram: {DD_DEPTH{SPACE_CODE}}, key_reg: KEY_NONE, key_out: KEY_NONE, default: '0
    };

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

    state_t     s;
    state_t     next_s;
    logic [7:0] mk_index;
    logic [7:0] ac_step;
    logic [5:0] opcode;

    // ==========================================
    // Key encoding
    // ==========================================
    // Return lines land one-hot in the upper nibble, the scan line as a
    // three-bit number in the low bits. Presses on one scan line merge
    // cleanly; presses on one return line keep only the lowest scan line.
    function automatic logic [7:0] encode_keys(input logic [3:0] ret, input logic [7:0] scan);
        logic [2:0] idx;
        idx = '0;
        for (int i = 7; i >= 0; i--) begin
            if (scan[i]) begin
                idx = 3'(i);
            end
        end
        if (ret == '0 || scan == '0) begin
            encode_keys = KEY_NONE;
        end else begin
            encode_keys = {ret, 1'b0, idx};
        end
    endfunction

    function automatic logic [7:0] step_addr(input logic [7:0] a, input logic up);
        step_addr = up ? 8'(a + 8'h01) : 8'(a - 8'h01);
    endfunction

    assign mk_index = 8'(s.ac - MK_BASE);
    assign opcode   = s.instruction_holding_reg[OP_HI:OP_LO];
    assign ac_step  = step_addr(s.ac, s.inc);

    // ==========================================
    // Next state
    // ==========================================
    always_comb begin
        next_s = s;
        next_s.key_vld = 1'b0;
        next_s.tick = 1'b0;

        // Oscillator rate enable; every busy time counts these ticks.
        if (s.div == DIV_LAST) begin
            next_s.div = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.div = DIV_W'(s.div + 1'b1);
        end

        // Busy countdown after init, reset release or a timed instruction.
        if ((s.st == ST_INIT || s.st == ST_BUSY) && s.tick) begin
            if (s.busy_cnt <= 8'h01) begin
                next_s.st = ST_IDLE;
                next_s.busy = 1'b0;
                next_s.busy_cnt = '0;
            end else begin
                next_s.busy_cnt = 8'(s.busy_cnt - 8'h01);
            end
        end

        // Key register follows the scanner unless an instruction is pending.
        if (key_sample_valid && !s.pend) begin
            next_s.key_reg = s.kscan ? encode_keys(key_return_lines, key_scan_lines) : KEY_NONE;
        end

        // Accept a word with our select code into the holding registers.
        if (instr_valid && s.st == ST_IDLE && !s.pend
                && instr_word[SEL_HI:SEL_LO] == OWN_SELECT) begin
            next_s.instruction_holding_reg = instr_word;
            next_s.data_holding_reg = instr_word[7:0];
            next_s.pend = 1'b1;
            next_s.busy = 1'b1;
        end

        // Execute the held instruction one cycle after acceptance.
        if (s.pend) begin
            next_s.pend = 1'b0;
            next_s.busy = 1'b0;
            next_s.st = ST_IDLE;
            case (opcode)
                OP_TEST: begin
                    next_s.test = 1'b1;
                end
                OP_CLEAR: begin
                    next_s.display_text_ram = {DD_DEPTH{SPACE_CODE}};
                    next_s.ac = HOME_ADDR;
                    next_s.tgt = TGT_DD;
                    next_s.inc = 1'b1;
                    next_s.busy = 1'b1;
                    next_s.st = ST_BUSY;
                    next_s.busy_cnt = CLEAR_TICKS;
                end
                OP_HOME: begin
                    next_s.ac = HOME_ADDR;
                    next_s.tgt = TGT_DD;
                    next_s.ofs = '0;
                end
                OP_ENTRY: begin
                    next_s.inc = s.data_holding_reg[1];
                    next_s.shf = s.data_holding_reg[0];
                end
                OP_DISP_CTL: begin
                    next_s.disp = s.data_holding_reg[2];
                    next_s.icon = s.data_holding_reg[1];
                    next_s.blink = s.data_holding_reg[0];
                end
                OP_ADDR_SHIFT: begin
                    next_s.ac = step_addr(s.ac, s.data_holding_reg[0]);
                end
                OP_DISP_SHIFT: begin
                    next_s.ofs = s.data_holding_reg[0] ? 5'(s.ofs + 5'h01) : 5'(s.ofs - 5'h01);
                end
                OP_PORT: begin
                    next_s.port = s.data_holding_reg[3:0];
                end
                OP_CONTRAST: begin
                    next_s.evr = s.data_holding_reg[3:0];
                end
                OP_DOT_SHIFT: begin
                    next_s.dots = s.data_holding_reg[2:0];
                end
                OP_DISP_MODE: begin
                    next_s.kscan = s.data_holding_reg[1];
                    next_s.pd = s.data_holding_reg[0];
                end
                OP_SET_DDMK: begin
                    next_s.ac = {3'h0, s.data_holding_reg[4:0]};
                    next_s.tgt = (s.data_holding_reg[4:0] >= MK_BASE[4:0]) ? TGT_MK : TGT_DD;
                end
                OP_SET_CG: begin
                    next_s.ac = s.data_holding_reg;
                    next_s.tgt = TGT_CG;
                end
                OP_WRITE: begin
                    case (s.tgt)
                        TGT_DD: begin
                            if (s.ac <= DD_LAST) begin
                                next_s.display_text_ram[s.ac[3:0]] = s.data_holding_reg;
                            end
                            if (s.shf) begin
                                next_s.ofs = s.inc ? 5'(s.ofs + 5'h01) : 5'(s.ofs - 5'h01);
                            end
                        end
                        TGT_MK: begin
                            if (s.ac >= MK_BASE && s.ac <= MK_LAST) begin
                                next_s.icon_ram[mk_index[3:0]] = s.data_holding_reg[FONT_W-1:0];
                            end
                        end
                        default: begin
                            next_s.glyph_ram[s.ac] = s.data_holding_reg[FONT_W-1:0];
                        end
                    endcase
                    next_s.ac = ac_step;
                    next_s.busy = 1'b1;
                    next_s.st = ST_BUSY;
                    next_s.busy_cnt = WRITE_TICKS;
                end
                OP_KEY_READ: begin
                    next_s.key_out = s.key_reg;
                    next_s.key_vld = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Reset pin: measure the low time in oscillator ticks.
        if (!reset_pin_n) begin
            if (s.tick && s.low_cnt != RST_LOW_TICKS) begin
                next_s.low_cnt = 8'(s.low_cnt + 8'h01);
            end
            if (s.low_cnt == RST_LOW_TICKS) begin
                next_s = RESET_STATE;
                next_s.div = s.div;
                next_s.tick = s.tick;
                next_s.low_cnt = s.low_cnt;
                next_s.st = ST_HOLD;
            end
        end else begin
            next_s.low_cnt = '0;
            if (s.st == ST_HOLD) begin
                next_s.st = ST_BUSY;
                next_s.busy = 1'b1;
                next_s.busy_cnt = RST_BUSY_TICKS;
            end
        end
    end

    // ==========================================
    // Registers
    // ==========================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // Outputs
    // ==========================================
    assign init_busy_flag  = s.busy;
    assign address_counter = s.ac;
    assign entry_increment = s.inc;
    assign entry_shift     = s.shf;
    assign display_offset  = s.ofs;
    assign display_on      = s.disp;
    assign icon_on         = s.icon;
    assign blink_on        = s.blink;
    assign static_port     = s.port;
    assign contrast        = s.evr;
    assign dot_shift       = s.dots;
    assign keyscan_on      = s.kscan;
    assign power_down      = s.pd;
    assign key_read_data   = s.key_out;
    assign key_read_valid  = s.key_vld;
    assign test_mode       = s.test;

endmodule : lcd_instruction_decoder

`default_nettype wire

// ### test/lcd_decoder_checker.sv
// Port-level assertions for the instruction decoder.
`timescale 1ns/1ps
`default_nettype none
module lcd_decoder_checker
    import lcd_decoder_pkg::*;
#(
    parameter logic [1:0] OWN_SELECT = SEL_MASTER
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        reset_pin_n,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic        init_busy_flag,
    input wire logic [7:0]  address_counter,
    input wire logic        entry_increment,
    input wire logic        entry_shift,
    input wire logic [4:0]  display_offset,
    input wire logic [7:0]  key_read_data,
    input wire logic        key_read_valid,
    input wire logic        test_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic       take;
    logic [5:0] op;
    assign op = instr_word[13:8];
    assign take = instr_valid && instr_word[15:14] == OWN_SELECT && !init_busy_flag && reset_pin_n;
    AST_FOREIGN: assert property (instr_valid && instr_word[15:14] != OWN_SELECT && !init_busy_flag
        && reset_pin_n |=> !init_busy_flag && $stable(address_counter)) else $error("foreign word acted on");
    AST_TAKE: assert property (take |=> init_busy_flag) else $error("busy not raised");
    AST_ZERO: assert property (take && op == OP_SET_DDMK |=> init_busy_flag ##1 !init_busy_flag)
        else $error("address set not zero time");
    AST_HOME: assert property (take && op == OP_HOME |=> ##1 address_counter == HOME_ADDR
        && display_offset == 5'h00) else $error("home wrong");
    AST_CLEAR: assert property (take && op == OP_CLEAR |=> ##1 address_counter == HOME_ADDR
        && entry_increment && entry_shift == $past(entry_shift, 2)) else $error("clear wrong");
    AST_WRITE_BUSY: assert property (take && op == OP_WRITE |=> init_busy_flag [*8])
        else $error("write busy short");
    AST_KEY: assert property (take && op == OP_KEY_READ |=> !key_read_valid ##1 key_read_valid
        ##1 !key_read_valid) else $error("key pulse wrong");
    AST_KEY_HOLD: assert property ($changed(key_read_data) |-> key_read_valid || !$past(reset_pin_n))
        else $error("key data moved");
    AST_TEST: assert property (test_mode && reset_pin_n |=> test_mode) else $error("test mode lost");
endmodule // lcd_decoder_checker
bind lcd_instruction_decoder lcd_decoder_checker #(.OWN_SELECT(OWN_SELECT)) chk_u (
    .mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .init_busy_flag(init_busy_flag), .address_counter(address_counter),
    .entry_increment(entry_increment), .entry_shift(entry_shift), .display_offset(display_offset),
    .key_read_data(key_read_data), .key_read_valid(key_read_valid), .test_mode(test_mode));
`default_nettype wire

// ### test/host_model.sv
// Host microcontroller model that sends instruction words.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        mclk,
    input  wire logic        init_busy_flag,
    output var  logic        instr_valid,
    output var  logic [15:0] instr_word
);
    initial begin
        instr_valid = 1'b0;
        instr_word  = 16'hA5A5;
    end
    // Lets one edge pass, waits out busy, then pulses the word if it is nonzero.
    task automatic send(input logic [15:0] word);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #2;
            n++;
        end while (init_busy_flag !== 1'b0 && n < 4000);
        if (word !== 16'h0000) begin
            instr_valid = 1'b1;
            instr_word  = word;
            @(posedge mclk);
            #2;
            instr_valid = 1'b0;
            instr_word  = ~word;
        end
    endtask
endmodule // host_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lcd_decoder_pkg::*;
    localparam int DIV = 4;
    logic        mclk, rst, reset_pin_n, instr_valid, key_sample_valid, init_busy_flag;
    logic        entry_increment, entry_shift, key_read_valid, test_mode, m_inc, m_shift, m_test;
    logic [15:0] instr_word, m_ctl;
    logic        display_on, icon_on, blink_on, keyscan_on, power_down;
    logic [2:0]  dot_shift;
    logic [7:0]  address_counter, key_read_data, key_scan_lines, m_addr, m_key, a;
    logic [4:0]  display_offset;
    logic [3:0]  key_return_lines, static_port, contrast;
    int          bad_count = 0, comparisons = 0, cycles = 0, k;
    lcd_instruction_decoder #(.OSC_DIV(DIV)) dut_u (
        .mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .key_sample_valid(key_sample_valid),
        .key_return_lines(key_return_lines), .key_scan_lines(key_scan_lines),
        .init_busy_flag(init_busy_flag), .address_counter(address_counter),
        .entry_increment(entry_increment), .entry_shift(entry_shift), .display_offset(display_offset),
        .display_on(display_on), .icon_on(icon_on), .blink_on(blink_on), .static_port(static_port),
        .contrast(contrast), .dot_shift(dot_shift), .keyscan_on(keyscan_on), .power_down(power_down),
        .key_read_data(key_read_data), .key_read_valid(key_read_valid),
        .test_mode(test_mode));
    host_model host_u (.mclk(mclk), .init_busy_flag(init_busy_flag), .instr_valid(instr_valid),
        .instr_word(instr_word));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge mclk);
        #2;
    endtask
    // Counts busy cycles; t<0 expects none, t=0 one cycle, else t oscillator ticks.
    task automatic wait_idle(input int t);
        int n;
        logic ok;
        n = 0;
        while (init_busy_flag === 1'b1 && n < 2000) begin
            step();
            n++;
        end
        ok = (t < 0) ? (n == 0) : (t == 0) ? (n == 1) : (n >= (t - 1) * DIV && n <= t * DIV + 4);
        check({15'h0, ok}, 16'h1);
    endtask
    task automatic issue(input logic [1:0] sel, input logic [5:0] op, input logic [7:0] arg, input int t);
        host_u.send({sel, op, arg});
        wait_idle(t);
        if (sel == SEL_MASTER) begin
            case (op)
                OP_SET_DDMK, OP_SET_CG: m_addr = arg;
                OP_DISP_CTL: m_ctl[15:13] = arg[2:0];
                OP_PORT: m_ctl[12:9] = arg[3:0];
                OP_CONTRAST: m_ctl[8:5] = arg[3:0];
                OP_DOT_SHIFT: m_ctl[4:2] = arg[2:0];
                OP_DISP_MODE: m_ctl[1:0] = arg[1:0];
                OP_WRITE: m_addr = m_inc ? m_addr + 8'h01 : m_addr - 8'h01;
                OP_ADDR_SHIFT: m_addr = arg[0] ? m_addr + 8'h01 : m_addr - 8'h01;
                OP_ENTRY: {m_inc, m_shift} = arg[1:0];
                OP_CLEAR: {m_addr, m_inc} = {HOME_ADDR, 1'b1};
                OP_HOME: m_addr = HOME_ADDR;
                OP_TEST: m_test = 1'b1;
                OP_KEY_READ: check({7'h0, key_read_valid, key_read_data}, {8'h01, m_key});
                default: m_test = m_test;
            endcase
        end
        check({8'h00, address_counter}, {8'h00, m_addr});
        check({14'h0, entry_increment, entry_shift}, {14'h0, m_inc, m_shift});
        check({15'h0, test_mode}, {15'h0, m_test});
        check({display_on, icon_on, blink_on, static_port, contrast, dot_shift, keyscan_on, power_down}, m_ctl);
    endtask
    task automatic key_sample(input logic [3:0] ret, input logic [7:0] scan);
        key_return_lines = ret;
        key_scan_lines = scan;
        key_sample_valid = 1'b1;
        step();
        key_sample_valid = 1'b0;
        m_key = KEY_NONE;
        for (int i = 7; i >= 0; i--) begin
            if (scan[i] && ret != 4'h0) m_key = {ret, 1'b0, 3'(i)};
        end
    endtask
    initial begin
        {rst, reset_pin_n, key_sample_valid, key_return_lines, key_scan_lines} = {2'b11, 13'h0};
        {m_addr, m_key, m_inc, m_shift, m_test} = {HOME_ADDR, KEY_NONE, 3'b100};
        m_ctl = 16'h0002;
        void'($urandom(32'h38154EF6));
        repeat (5) @(posedge mclk);
        #2;
        rst = 1'b0;
        check({15'h0, init_busy_flag}, 16'h1);
        wait_idle(int'(INIT_TICKS));
        issue(SEL_MASTER, OP_ENTRY, 8'h02, 0);
        for (k = 0; k < 4; k++) begin
            a = 8'($urandom_range(10, 1));
            issue(SEL_MASTER, OP_SET_DDMK, a, 0);
            issue(SEL_SLAVE, OP_SET_DDMK, a + 8'h01, -1);
            issue(SEL_MASTER, OP_WRITE, 8'($urandom_range(255, 0)), int'(WRITE_TICKS));
            issue(SEL_MASTER, OP_ADDR_SHIFT, {7'h0, k[0]}, 0);
        end
        issue(SEL_MASTER, OP_ENTRY, 8'h01, 0);
        issue(SEL_MASTER, OP_CLEAR, 8'h00, int'(CLEAR_TICKS));
        issue(SEL_MASTER, OP_DISP_SHIFT, 8'h01, 0);
        check({11'h0, display_offset}, 16'h0001);
        issue(SEL_MASTER, OP_SET_DDMK, 8'h07, 0);
        issue(SEL_MASTER, OP_HOME, 8'h00, 0);
        check({11'h0, display_offset}, 16'h0);
        for (k = 0; k < 8; k++) begin
            key_sample(k == 0 ? 4'h0 : 4'($urandom_range(15, 1)), 8'h01 << $urandom_range(7, 0));
            issue(SEL_MASTER, OP_KEY_READ, 8'h00, 0);
        end
        issue(SEL_MASTER, OP_SET_CG, 8'h1F, 0);
        issue(SEL_MASTER, OP_WRITE, 8'($urandom), int'(WRITE_TICKS));
        issue(SEL_MASTER, OP_SET_DDMK, MK_BASE, 0);
        issue(SEL_MASTER, OP_WRITE, 8'($urandom), int'(WRITE_TICKS));
        issue(SEL_MASTER, OP_SET_DDMK, 8'h0C, 0);
        repeat (2) issue(SEL_MASTER, OP_WRITE, 8'($urandom), int'(WRITE_TICKS));
        issue(SEL_SLAVE, OP_SET_DDMK, 8'h01, -1);
        for (k = 0; k < 6; k++) begin
            issue(SEL_MASTER, OP_DISP_CTL + 6'(k), 8'($urandom), 0);
        end
        issue(SEL_MASTER, OP_SET_DDMK, 8'h05, 0);
        reset_pin_n = 1'b0;
        repeat (100 * DIV) step();
        reset_pin_n = 1'b1;
        step();
        check({7'h0, init_busy_flag, address_counter}, 16'h0005);
        reset_pin_n = 1'b0;
        repeat ((int'(RST_LOW_TICKS) + 3) * DIV) step();
        check({7'h0, init_busy_flag, key_read_data}, {8'h01, KEY_NONE});
        reset_pin_n = 1'b1;
        {m_addr, m_inc, m_shift} = {HOME_ADDR, 2'b10};
        m_ctl = 16'h0002;
        wait_idle(int'(RST_BUSY_TICKS));
        issue(SEL_MASTER, OP_ADDR_SHIFT, 8'h01, 0);
        issue(SEL_MASTER, OP_TEST, 8'h00, 0);
        repeat (4) step();
        check({15'h0, test_mode}, 16'h1);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
